// ---- rtc_consts.svh ----
// Function
// R01 - a read sends its first byte from the register the pointer selects
// R02 - without a pointer write, a read starts where the pointer last stood
// R03 - the pointer advances by one after every byte, read or write
// R04 - the master ends a read with a not-acknowledge so the data line is released
// R05 - with century enable set, the century flag inverts at each century rollover
// R06 - day of week sits in bits 2..0 of register 3, counting 1 to 7
// R07 - a one in the halt bit stops the oscillator and all timekeeping
// R08 - once the halt bit clears, the oscillator runs again within one second
// R09 - user buffers reload from the counters at start, stop and pointer wrap
// R10 - any write to the seconds register restarts the sub-second chain
// R11 - a written byte commits to the counters at its acknowledge
// R12 - the master writes the other time registers within one second of seconds
// R13 - the half-second square wave edge comes 500 ms after a seconds write; the code's first sec_tog edge comes one second after it
// R14 - the master sets then clears the halt bit once after first power-up
// R15 - counters run in packed decimal with tens digits in the upper bits
// R16 - the master writes reserved bits with their default value
// R17 - test bit low: pin follows the level bit; test bit high: pin gives 512 Hz
// R18 - at power-up the test bit clears and the output level bit sets
// R19 - only bus address 1101000 is answered; direction bit zero writes, one reads
// R20 - the first written byte loads the pointer; later bytes store at successive places
// R21 - with supply below threshold, abort the access, clear the pointer, ignore the bus
// R22 - the date advances at midnight with month lengths, leap years and decimal carry
// R23 - the one-second tick divides the 32.768 kHz crystal through the chain
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH
`define RTC_I2C_ADDR     7'h68
`define RTC_BYTE_BITS    4'h8
`define RTC_BIT_ONE      4'h1
`define RTC_PTR_LAST     3'h7
`define RTC_SEC          3'h0
`define RTC_MIN          3'h1
`define RTC_HOUR         3'h2
`define RTC_WDAY         3'h3
`define RTC_DATE         3'h4
`define RTC_MON          3'h5
`define RTC_YEAR         3'h6
`define RTC_CTRL         3'h7
`define RTC_HALT_BIT     7
`define RTC_CEN_EN_BIT   7
`define RTC_CEN_FLAG_BIT 6
`define RTC_OUT_BIT      7
`define RTC_FT_BIT       6
`define RTC_CTRL_RST     8'h80
`define RTC_BCD_ZERO     8'h00
`define RTC_BCD_ONE      8'h01
`define RTC_WR_MASKS     64'hc0ff1f3f07ff7fff
`define RTC_MAX_SEC      8'h59
`define RTC_MAX_HOUR     8'h23
`define RTC_MAX_MON      8'h12
`define RTC_MAX_YEAR     8'h99
`define RTC_FEB          8'h02
`define RTC_D28          8'h28
`define RTC_D29          8'h29
`define RTC_D30          8'h30
`define RTC_D31          8'h31
`define RTC_WDAY_MAX     3'h7
`define RTC_WDAY_MIN     3'h1
`define RTC_XTAL_HZ      32768
`define RTC_TEST_HZ      512
`define RTC_DIV_W        $clog2(`RTC_XTAL_HZ)
`define RTC_F512_BIT     ($clog2(`RTC_XTAL_HZ / `RTC_TEST_HZ) - 1)
`endif

// ---- rtc_pkg.sv ----
package rtc_pkg;
  typedef enum logic [2:0] {s_idle, s_addr, s_ack, s_wbyte, s_rbyte, s_mack} bus_state_t;
  typedef struct packed {
    logic scl;
    logic sda;
  } bus_pins_t;
  typedef struct packed {
    logic sec_tog;
    logic f512;
  } osc_out_t;
  typedef logic [7:0] byte_t;
endpackage : rtc_pkg

// ---- osc_chain.sv ----
`timescale 1ns/1ps
`include "rtc_consts.svh"
module osc_chain #(
  parameter int div_w = `RTC_DIV_W
) (
  // crystal clock
  input  wire logic        osc_clk,
  // controls from the system clock domain
  input  wire logic        rst,
  input  wire logic        halt,
  input  wire logic        restart_tog,
  // toward the system clock domain
  output rtc_pkg::osc_out_t osc_out
);
  logic [1:0]       rst_s;
  logic [1:0]       halt_s;
  logic [1:0]       rtog_s;
  logic             rtog_q;
  logic             sec_tog_q;
  logic [div_w-1:0] cnt_q;

  always_ff @(posedge osc_clk) begin
    rst_s  <= {rst_s[0], rst};
    halt_s <= {halt_s[0], halt};
    rtog_s <= {rtog_s[0], restart_tog};
  end

  // halt freezes the chain without clearing it, so restart is immediate
  always_ff @(posedge osc_clk) begin
    if (rst_s[1]) begin
      cnt_q     <= '0;
      sec_tog_q <= 1'b0;
      rtog_q    <= 1'b0;
    end else begin
      rtog_q <= rtog_s[1];
      if (rtog_s[1] ^ rtog_q) begin
        cnt_q <= '0; // [R10] [R13]
      end else if (!halt_s[1]) begin
        cnt_q <= cnt_q + div_w'(1); // [R07] [R08] [R23]
        if (&cnt_q) begin
          sec_tog_q <= ~sec_tog_q; // [R23]
        end
      end
    end
  end

  // sec_tog_q toggles each time the chain wraps: its first edge comes one full count, one second, after restart
  assign osc_out.sec_tog = sec_tog_q;
  assign osc_out.f512    = cnt_q[`RTC_F512_BIT]; // [R17]
endmodule : osc_chain

// ---- serial_bcd_rtc_core.sv ----
`timescale 1ns/1ps
`include "rtc_consts.svh"
module serial_bcd_rtc_core #(
  parameter int div_w = `RTC_DIV_W
) (
  // system clock
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic ce,
  // crystal clock
  input  wire logic osc_clk,
  // two-wire bus pins
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  // supply monitor, high while supply is below threshold
  input  wire logic backup_switch_threshold,
  // open-drain output pin
  output logic      test_level_output_pin_o,
  output logic      test_level_output_pin_oe
);
  localparam logic [63:0] wr_masks = `RTC_WR_MASKS;

  rtc_pkg::bus_pins_t   pin_s1;
  rtc_pkg::bus_pins_t   pin_s2;
  rtc_pkg::bus_pins_t   pin_q;
  rtc_pkg::osc_out_t    osc_out;
  rtc_pkg::bus_state_t  state_q;
  rtc_pkg::byte_t       time_q [8];
  rtc_pkg::byte_t       user_q [8];
  rtc_pkg::byte_t       shreg_q;
  rtc_pkg::byte_t       rd_byte;
  rtc_pkg::byte_t       wr_byte;
  logic [1:0]           vlow_s;
  logic [2:0]           sec_s;
  logic [1:0]           f512_s;
  logic [3:0]           bit_cnt_q;
  logic [2:0]           ptr_q;
  logic                 rw_q;
  logic                 first_q;
  logic                 restart_tog_q;
  logic                 vlow;
  logic                 start;
  logic                 stop;
  logic                 rise;
  logic                 fall;
  logic                 wr_en;
  logic                 rd_done;
  logic                 ptr_inc;
  logic                 sync_buf;
  logic                 tick_en;
  logic                 day_c;
  logic                 cen_roll;
  logic [8:0]           s_n;
  logic [8:0]           m_n;
  logic [8:0]           h_n;
  logic [8:0]           dt_n;
  logic [8:0]           mo_n;
  logic [8:0]           y_n;

  function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] top,
                                         input logic [7:0] low);
    if (v >= top) begin
      return {1'b1, low};
    end
    if (v[3:0] == 4'h9) begin
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    end
    return {1'b0, v + 8'h01};
  endfunction : bcd_inc

  function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = (((y[4] ? 4'h2 : 4'h0) + y[3:0]) & 4'h3) == 4'h0;
    case (m)
      `RTC_FEB:                       return leap ? `RTC_D29 : `RTC_D28;
      8'h04, 8'h06, 8'h09, 8'h11:    return `RTC_D30;
      default:                        return `RTC_D31;
    endcase
  endfunction : month_days

  osc_chain #(
    .div_w(div_w)
  ) u_chain (
    .osc_clk    (osc_clk),
    .rst        (rst),
    .halt       (time_q[`RTC_SEC][`RTC_HALT_BIT]),
    .restart_tog(restart_tog_q),
    .osc_out    (osc_out)
  );

  // pins and crossings; the first stage feeds no logic
  always_ff @(posedge mclk) begin
    if (ce) begin
      pin_s1 <= {scl_i, sda_i};
      pin_s2 <= pin_s1;
      pin_q  <= pin_s2;
      vlow_s <= {vlow_s[0], backup_switch_threshold};
      sec_s  <= {sec_s[1:0], osc_out.sec_tog};
      f512_s <= {f512_s[0], osc_out.f512};
    end
  end

  assign vlow     = vlow_s[1];
  assign start    = pin_q.scl & pin_s2.scl & pin_q.sda & ~pin_s2.sda;
  assign stop     = pin_q.scl & pin_s2.scl & ~pin_q.sda & pin_s2.sda;
  assign rise     = ~pin_q.scl & pin_s2.scl;
  assign fall     = pin_q.scl & ~pin_s2.scl;
  assign rd_byte  = user_q[ptr_q];
  assign wr_byte  = shreg_q & wr_masks[{ptr_q, 3'h0} +: 8];
  assign wr_en    = ce && !vlow && state_q == rtc_pkg::s_wbyte && fall
                    && bit_cnt_q == `RTC_BYTE_BITS && !first_q;
  assign rd_done  = ce && !vlow && state_q == rtc_pkg::s_rbyte && fall
                    && bit_cnt_q == `RTC_BYTE_BITS;
  assign ptr_inc  = wr_en || rd_done;
  assign sync_buf = ce && (start || stop || (ptr_inc && ptr_q == `RTC_PTR_LAST)); // [R09]
  assign tick_en  = ce && (sec_s[1] ^ sec_s[2]) && !time_q[`RTC_SEC][`RTC_HALT_BIT]; // [R07]

  // bus slave: start and stop win over any bit activity
  always_ff @(posedge mclk) begin
    if (rst || (ce && vlow)) begin
      state_q   <= rtc_pkg::s_idle; // [R21]
      bit_cnt_q <= '0;
      shreg_q   <= '0;
      ptr_q     <= '0; // [R21]
      rw_q      <= 1'b0;
      first_q   <= 1'b0;
      sda_oe    <= 1'b0;
    end else if (ce) begin
      if (start) begin
        state_q   <= rtc_pkg::s_addr;
        bit_cnt_q <= '0;
        sda_oe    <= 1'b0;
      end else if (stop) begin
        state_q <= rtc_pkg::s_idle;
        sda_oe  <= 1'b0;
      end else begin
        unique case (state_q)
          rtc_pkg::s_idle: begin
            bit_cnt_q <= '0;
          end
          rtc_pkg::s_addr, rtc_pkg::s_wbyte: begin
            if (rise && bit_cnt_q != `RTC_BYTE_BITS) begin
              shreg_q   <= {shreg_q[6:0], pin_s2.sda};
              bit_cnt_q <= bit_cnt_q + `RTC_BIT_ONE;
            end else if (fall && bit_cnt_q == `RTC_BYTE_BITS) begin
              if (state_q == rtc_pkg::s_addr && shreg_q[7:1] != `RTC_I2C_ADDR) begin
                state_q <= rtc_pkg::s_idle; // [R19]
              end else begin
                state_q <= rtc_pkg::s_ack;
                sda_oe  <= 1'b1;
                if (state_q == rtc_pkg::s_addr) begin
                  rw_q    <= shreg_q[0]; // [R19]
                  first_q <= ~shreg_q[0];
                end else begin
                  first_q <= 1'b0;
                  if (first_q) begin
                    ptr_q <= shreg_q[2:0]; // [R20]
                  end else begin
                    ptr_q <= ptr_q + 3'h1; // [R03] [R20]
                  end
                end
              end
            end
          end
          rtc_pkg::s_ack: begin
            if (fall) begin
              if (rw_q) begin
                shreg_q   <= rd_byte; // [R01] [R02]
                sda_oe    <= ~rd_byte[7];
                bit_cnt_q <= `RTC_BIT_ONE;
                state_q   <= rtc_pkg::s_rbyte;
              end else begin
                sda_oe    <= 1'b0;
                bit_cnt_q <= '0;
                state_q   <= rtc_pkg::s_wbyte;
              end
            end
          end
          rtc_pkg::s_rbyte: begin
            if (fall) begin
              if (bit_cnt_q == `RTC_BYTE_BITS) begin
                sda_oe  <= 1'b0;
                state_q <= rtc_pkg::s_mack;
                ptr_q   <= ptr_q + 3'h1; // [R03]
              end else begin
                sda_oe    <= ~shreg_q[6];
                shreg_q   <= {shreg_q[6:0], 1'b0};
                bit_cnt_q <= bit_cnt_q + `RTC_BIT_ONE;
              end
            end
          end
          rtc_pkg::s_mack: begin
            if (rise && pin_s2.sda) begin
              state_q <= rtc_pkg::s_idle; // [R04]
            end else if (fall) begin
              shreg_q   <= rd_byte; // [R01]
              sda_oe    <= ~rd_byte[7];
              bit_cnt_q <= `RTC_BIT_ONE;
              state_q   <= rtc_pkg::s_rbyte;
            end
          end
        endcase
      end
    end
  end

  // seconds write restarts the crystal chain in the other domain
  always_ff @(posedge mclk) begin
    if (rst) begin
      restart_tog_q <= 1'b0;
    end else if (wr_en && ptr_q == `RTC_SEC) begin
      restart_tog_q <= ~restart_tog_q; // [R10]
    end
  end

  always_comb begin
    s_n  = bcd_inc({1'b0, time_q[`RTC_SEC][6:0]}, `RTC_MAX_SEC, `RTC_BCD_ZERO); // [R15]
    m_n  = bcd_inc({1'b0, time_q[`RTC_MIN][6:0]}, `RTC_MAX_SEC, `RTC_BCD_ZERO);
    h_n  = bcd_inc({2'h0, time_q[`RTC_HOUR][5:0]}, `RTC_MAX_HOUR, `RTC_BCD_ZERO);
    dt_n = bcd_inc({2'h0, time_q[`RTC_DATE][5:0]},
                   month_days({3'h0, time_q[`RTC_MON][4:0]}, time_q[`RTC_YEAR]), `RTC_BCD_ONE); // [R22]
    mo_n = bcd_inc({3'h0, time_q[`RTC_MON][4:0]}, `RTC_MAX_MON, `RTC_BCD_ONE);
    y_n  = bcd_inc(time_q[`RTC_YEAR], `RTC_MAX_YEAR, `RTC_BCD_ZERO);
  end

  assign day_c    = tick_en && s_n[8] && m_n[8] && h_n[8];
  assign cen_roll = day_c && dt_n[8] && mo_n[8] && y_n[8] && time_q[`RTC_HOUR][`RTC_CEN_EN_BIT];

  // counters; a byte written in the same cycle as a tick overrides that register
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        time_q[i] <= '0;
      end
      time_q[`RTC_WDAY] <= `RTC_BCD_ONE;
      time_q[`RTC_DATE] <= `RTC_BCD_ONE;
      time_q[`RTC_MON]  <= `RTC_BCD_ONE;
      time_q[`RTC_CTRL] <= `RTC_CTRL_RST; // [R18]
    end else begin
      if (tick_en) begin
        time_q[`RTC_SEC][6:0] <= s_n[6:0]; // [R15] [R23]
        if (s_n[8]) begin
          time_q[`RTC_MIN][6:0] <= m_n[6:0];
        end
        if (s_n[8] && m_n[8]) begin
          time_q[`RTC_HOUR][5:0] <= h_n[5:0];
        end
        if (day_c) begin
          time_q[`RTC_WDAY][2:0] <= (time_q[`RTC_WDAY][2:0] >= `RTC_WDAY_MAX) ?
                                    `RTC_WDAY_MIN : time_q[`RTC_WDAY][2:0] + 3'h1; // [R06]
          time_q[`RTC_DATE][5:0] <= dt_n[5:0]; // [R22]
          if (dt_n[8]) begin
            time_q[`RTC_MON][4:0] <= mo_n[4:0];
          end
          if (dt_n[8] && mo_n[8]) begin
            time_q[`RTC_YEAR] <= y_n[7:0];
          end
        end
        if (cen_roll) begin
          time_q[`RTC_HOUR][`RTC_CEN_FLAG_BIT] <= ~time_q[`RTC_HOUR][`RTC_CEN_FLAG_BIT]; // [R05]
        end
      end
      if (wr_en) begin
        time_q[ptr_q] <= wr_byte; // [R11]
      end
    end
  end

  // user buffers shield bus reads from counter updates
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        user_q[i] <= '0;
      end
    end else begin
      if (sync_buf) begin
        user_q <= time_q; // [R09]
      end
      if (wr_en) begin
        user_q[ptr_q] <= wr_byte; // [R11]
      end
    end
  end

  // open drain: enable pulls low, so a released pin reads high
  always_ff @(posedge mclk) begin
    if (rst) begin
      sda_o                    <= 1'b0;
      test_level_output_pin_o  <= 1'b0;
      test_level_output_pin_oe <= 1'b0; // [R18]
    end else if (ce) begin
      if (time_q[`RTC_CTRL][`RTC_FT_BIT]) begin
        test_level_output_pin_oe <= ~f512_s[1]; // [R17]
      end else begin
        test_level_output_pin_oe <= ~time_q[`RTC_CTRL][`RTC_OUT_BIT]; // [R17]
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence byte_acked_s;
    wr_en;
  endsequence
  sequence ack_driven_s;
    sda_oe && state_q == rtc_pkg::s_ack;
  endsequence
  sequence rd_load_s;
    ce && !vlow && !start && !stop && state_q == rtc_pkg::s_ack && fall && rw_q;
  endsequence

  a_ptr_advance: assert property (ptr_inc |=> ptr_q == $past(ptr_q) + 3'h1) // [R03]
    else $error("pointer did not advance");
  a_ptr_load: assert property (ce && !vlow && !start && !stop && state_q == rtc_pkg::s_wbyte && fall
                               && bit_cnt_q == `RTC_BYTE_BITS && first_q
                               |=> ptr_q == $past(shreg_q[2:0])) // [R20]
    else $error("pointer not loaded from first byte");
  a_commit_ack: assert property (byte_acked_s |=> ack_driven_s ##0 time_q[$past(ptr_q)] == $past(wr_byte)) // [R11]
    else $error("write not committed at acknowledge");
  a_read_first: assert property (rd_load_s |=> shreg_q == $past(rd_byte) ##0 sda_oe == ~shreg_q[7]) // [R01]
    else $error("read did not start at pointer");
  a_addr_match: assert property (ce && !vlow && !start && !stop && state_q == rtc_pkg::s_addr && fall
                                 && bit_cnt_q == `RTC_BYTE_BITS && shreg_q[7:1] != `RTC_I2C_ADDR
                                 |=> state_q == rtc_pkg::s_idle && !sda_oe) // [R19]
    else $error("foreign address answered");
  a_supply_abort: assert property (ce && vlow |=> state_q == rtc_pkg::s_idle && ptr_q == 3'h0 && !sda_oe) // [R21]
    else $error("access not aborted on low supply");
  a_cen_toggle: assert property (cen_roll && !wr_en
                                 |=> time_q[`RTC_HOUR][`RTC_CEN_FLAG_BIT]
                                     != $past(time_q[`RTC_HOUR][`RTC_CEN_FLAG_BIT])) // [R05]
    else $error("century flag did not invert");
  a_wday_wrap: assert property (day_c && !wr_en && time_q[`RTC_WDAY][2:0] == `RTC_WDAY_MAX
                                |=> time_q[`RTC_WDAY][2:0] == `RTC_WDAY_MIN) // [R06]
    else $error("weekday did not wrap to one");
  a_buf_sync: assert property (ce && (start || stop) && !wr_en |=> user_q[3'h0] == $past(time_q[3'h0])) // [R09]
    else $error("user buffer not reloaded");
  a_sec_restart: assert property (wr_en && ptr_q == `RTC_SEC |=> restart_tog_q != $past(restart_tog_q)) // [R10]
    else $error("seconds write did not restart chain");
  a_pin_level: assert property (ce && !time_q[`RTC_CTRL][`RTC_FT_BIT]
                                |=> test_level_output_pin_oe == !$past(time_q[`RTC_CTRL][`RTC_OUT_BIT])) // [R17]
    else $error("pin does not follow level bit");
endmodule : serial_bcd_rtc_core

// ---- i2c_master_model.sv ----
`timescale 1ns/1ps
module i2c_master_model #(
  parameter int half = 6
) (
  // system clock and resolved data wire
  input  wire logic mclk,
  input  wire logic sda_i,
  // bus drive, sda_low_o high pulls the data wire low
  output logic      scl_o,
  output logic      sda_low_o
);
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1ns;
  endtask : tick

  // data moves 2 cycles after the fall, so it is never seen as a start or stop
  task automatic pulse(input logic low, output logic seen);
    tick(2);
    sda_low_o = low;
    tick(half);
    scl_o = 1'b1;
    seen  = sda_i;
    tick(half);
    scl_o = 1'b0;
  endtask : pulse

  task automatic bus_start();
    tick(half);
    sda_low_o = 1'b1;
    tick(half);
    scl_o = 1'b0;
  endtask : bus_start

  task automatic bus_stop();
    tick(2);
    sda_low_o = 1'b1;
    tick(half);
    scl_o = 1'b1;
    tick(half);
    sda_low_o = 1'b0;
    tick(half);
  endtask : bus_stop

  task automatic send_byte(input rtc_pkg::byte_t b, output logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(~b[i], s);
    end
    pulse(1'b0, nack);
  endtask : send_byte

  task automatic recv_byte(input logic last, output rtc_pkg::byte_t b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(1'b0, s);
      b[i] = s;
    end
    pulse(~last, s);
  endtask : recv_byte
endmodule : i2c_master_model

// ---- serial_bcd_rtc_core_bench.sv ----
`timescale 1ns/1ps
module serial_bcd_rtc_core_bench;
  localparam int div_w   = 7;
  localparam int sec_cyc = 1280; // 2^7 crystal cycles of 80 ns in 8 ns cycles
  localparam int f_cyc   = 640;  // period of the 512 Hz chain bit
  logic           mclk    = 1'b0;
  logic           osc_clk = 1'b0;
  logic           rst     = 1'b1;
  logic           ce      = 1'b1;
  logic           low_sup = 1'b0;
  logic           scl;
  logic           m_low;
  logic           sda_o;
  logic           sda_oe;
  logic           pin_o;
  logic           pin_oe;
  wire logic      sda_w;
  wire logic      pin;
  int             n_fail     = 0;
  int             num_checks = 0;
  rtc_pkg::byte_t q [8];

  // pull-ups on both open-drain wires
  assign sda_w = ~(m_low | sda_oe);
  assign pin   = ~pin_oe;

  always #4 mclk = ~mclk;
  always begin
    #13;
    forever #40 osc_clk = ~osc_clk;
  end

  serial_bcd_rtc_core #(.div_w(div_w)) dut_u (
    .mclk(mclk), .rst(rst), .ce(ce), .osc_clk(osc_clk), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .backup_switch_threshold(low_sup),
    .test_level_output_pin_o(pin_o), .test_level_output_pin_oe(pin_oe));

  i2c_master_model master_u (.mclk(mclk), .sda_i(sda_w), .scl_o(scl), .sda_low_o(m_low));

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1ns;
  endtask : tick

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wr_regs(input rtc_pkg::byte_t ptr, input int n, input rtc_pkg::byte_t d [8]);
    logic nk;
    master_u.bus_start();
    master_u.send_byte(8'hd0, nk);
    check("write address ack", {7'h00, nk}, 8'h00);
    master_u.send_byte(ptr, nk);
    check("pointer ack", {7'h00, nk}, 8'h00);
    for (int i = 0; i < n; i++) begin
      master_u.send_byte(d[i], nk);
    end
    master_u.bus_stop();
  endtask : wr_regs

  task automatic rd_regs(input logic set_ptr, input rtc_pkg::byte_t ptr, input int n);
    logic nk;
    if (set_ptr) begin
      master_u.bus_start();
      master_u.send_byte(8'hd0, nk);
      master_u.send_byte(ptr, nk);
      master_u.bus_stop();
    end
    master_u.bus_start();
    master_u.send_byte(8'hd1, nk);
    check("read address ack", {7'h00, nk}, 8'h00);
    for (int i = 0; i < n; i++) begin
      master_u.recv_byte(i == n - 1, q[i]);
    end
    master_u.bus_stop();
  endtask : rd_regs

  task automatic t_defaults();
    rtc_pkg::byte_t e [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h80};
    rd_regs(1'b1, 8'h00, 8);
    for (int i = 0; i < 8; i++) begin
      check("reset register", q[i], e[i]);
    end
    check("pin after reset", {7'h00, pin}, 8'h01);
    check("data pin drive value", {7'h00, sda_o}, 8'h00);
    check("output pin drive value", {7'h00, pin_o}, 8'h00);
    $display("done defaults");
  endtask : t_defaults

  // every field written in one transfer, well inside the second
  task automatic t_rollover();
    rtc_pkg::byte_t e [8] = '{8'h00, 8'h00, 8'hc0, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
    wr_regs(8'h00, 8, '{8'h59, 8'h59, 8'ha3, 8'h07, 8'h31, 8'h12, 8'h99, 8'h00});
    tick(600);
    rd_regs(1'b1, 8'h00, 8);
    for (int i = 0; i < 8; i++) begin
      check("after rollover", q[i], e[i]);
    end
    check("pin level low", {7'h00, pin}, 8'h00);
    $display("done rollover");
  endtask : t_rollover

  task automatic t_current_ptr();
    rd_regs(1'b1, 8'h01, 1);
    check("pointed byte", q[0], 8'h00);
    rd_regs(1'b0, 8'h00, 2);
    check("current pointer", q[0], 8'hc0);
    check("next pointer", q[1], 8'h01);
    $display("done current pointer");
  endtask : t_current_ptr

  task automatic t_halt();
    wr_regs(8'h00, 1, '{0: 8'h90, default: 8'h00});
    tick(2 * sec_cyc + 100);
    rd_regs(1'b1, 8'h00, 1);
    check("halted seconds", q[0], 8'h90);
    $display("done halt");
  endtask : t_halt

  task automatic t_supply();
    logic nk;
    wr_regs(8'h03, 0, '{default: 8'h00});
    low_sup = 1'b1;
    tick(10);
    master_u.bus_start();
    master_u.send_byte(8'hd0, nk);
    check("ack with supply low", {7'h00, nk}, 8'h01);
    master_u.bus_stop();
    low_sup = 1'b0;
    tick(10);
    rd_regs(1'b0, 8'h00, 2);
    check("pointer cleared", q[0], 8'h90);
    check("pointer cleared next", q[1], 8'h00);
    $display("done supply");
  endtask : t_supply

  task automatic t_resume();
    wr_regs(8'h00, 1, '{0: 8'h10, default: 8'h00});
    tick(sec_cyc + 200);
    rd_regs(1'b1, 8'h00, 1);
    check("seconds after restart", q[0], 8'h11);
    $display("done resume");
  endtask : t_resume

  task automatic t_bad_addr();
    logic nk;
    master_u.bus_start();
    master_u.send_byte(8'hd2, nk);
    check("foreign address ack", {7'h00, nk}, 8'h01);
    master_u.bus_stop();
    $display("done bad address");
  endtask : t_bad_addr

  task automatic t_freq();
    int   edges;
    logic prev;
    edges = 0;
    wr_regs(8'h07, 1, '{0: 8'h40, default: 8'h00});
    tick(20);
    prev = pin;
    for (int i = 0; i < 4 * f_cyc; i++) begin
      tick(1);
      if (pin === 1'b1 && prev === 1'b0) begin
        edges++;
      end
      prev = pin;
    end
    check("test frequency edges", {7'h00, edges >= 3 && edges <= 5}, 8'h01);
    // half a test period: a running pin would show the opposite level
    ce   = 1'b0;
    prev = pin;
    tick(f_cyc / 2);
    check("pin frozen by enable", {7'h00, pin}, {7'h00, prev});
    ce = 1'b1;
    wr_regs(8'h07, 1, '{0: 8'h80, default: 8'h00});
    tick(10);
    check("pin level high", {7'h00, pin}, 8'h01);
    $display("done frequency");
  endtask : t_freq

  initial begin
    repeat (100000) @(posedge mclk);
    n_fail++;
    $display("unexpected timeout expected finish seen hang");
    tally_and_finish();
  end

  initial begin
    repeat (12) @(posedge mclk);
    #1ns;
    rst = 1'b0;
    tick(4);
    t_defaults();
    t_rollover();
    t_current_ptr();
    t_halt();
    t_supply();
    t_resume();
    t_bad_addr();
    t_freq();
    tally_and_finish();
  end
endmodule : serial_bcd_rtc_core_bench
